// ---- core/armd_core.sv ----
// armd_core: decode and execute of accumulator rotates, nibble swap and
// the accumulator / working register moves.
// assumes a code stream with valid/ready and internal ram whose read data
// is valid in the same cycle as the address (combinational read).
`timescale 1ns/1ns
module armd_core
    import armd_pkg::*;
(
    input  wire logic                clk,        // core clock, 100 mhz
    input  wire logic                srst,       // sync reset, active high
    input  wire logic                code_valid, // code byte present
    input  wire logic [7:0]          code_byte,  // opcode or operand byte
    output logic                     code_ready, // code byte taken this cycle if code_valid
    output armd_ram_req_t            ram_req,    // ram read strobe and address
    input  wire logic [7:0]          ram_rdata,  // ram read data, same cycle
    output logic [7:0]               acc,        // accumulator
    output logic                     cy,         // carry flag
    output logic [7:0][7:0]          rf,         // working registers r0..r7
    output logic                     done,       // last cycle of instruction
    output logic                     unhandled   // opcode outside this block
);

    // ==========================================================
    // state
    armd_state_t      state_q, state_d;
    armd_cls_t        cls_q, cls_d;
    logic [7:0]       op_q, op_d;
    logic [7:0]       tmp_q, tmp_d;
    logic [7:0]       acc_q, acc_d;
    logic             cy_q, cy_d;
    logic [7:0][7:0]  rf_q;

    // ==========================================================
    // decode
    wire armd_cls_t   cls_now   = armd_classify(code_byte);
    wire logic        in_op     = (state_q == ST_OP);
    wire logic        in_arg    = (state_q == ST_ARG);
    wire logic        op_take   = in_op && code_valid;
    wire logic        arg_take  = in_arg && code_valid;
    wire logic [2:0]  rn_now    = code_byte[2:0];
    wire logic [2:0]  rn_q      = op_q[2:0];
    wire logic [2:0]  ptr_q     = {2'b00, op_q[0]};
    wire logic [7:0]  rn_val    = rf_q[rn_now];
    wire logic [7:0]  ptr_val   = rf_q[ptr_q];
    wire logic        arg_read  = arg_take && (cls_q == CL_A_DIR || cls_q == CL_RN_DIR);
    wire logic        ind_read  = (state_q == ST_IND);
    wire logic        wr_rf     = (state_q == ST_WR);
    wire logic [7:0]  wr_val    = (cls_q == CL_RN_A) ? acc_q : tmp_q;

    // ram address is combinational: the direct address arrives in the same
    // cycle as its data is needed, a register stage would cost a cycle
    assign code_ready   = in_op || in_arg;
    assign ram_req.re   = arg_read || ind_read;
    assign ram_req.addr = ind_read ? ptr_val : code_byte;
    assign acc          = acc_q;
    assign cy           = cy_q;
    assign rf           = rf_q;
    assign unhandled    = op_take && (cls_now == CL_NONE);
    assign done = (op_take && cls_now inside {CL_NONE, CL_RLC, CL_RR, CL_RRC,
                                              CL_SWAP, CL_A_RN})
                || (arg_take && cls_q != CL_RN_DIR) || ind_read || wr_rf;

    // ==========================================================
    // sequencing
    always_comb begin
        state_d = state_q;
        cls_d   = cls_q;
        op_d    = op_q;
        case (state_q)
            ST_OP: begin
                if (code_valid) begin
                    cls_d = cls_now;
                    op_d  = code_byte;
                    case (cls_now)
                        CL_A_DIR, CL_A_IMM, CL_RN_DIR: state_d = ST_ARG;
                        CL_A_IND: state_d = ST_IND;
                        CL_RN_A: state_d = ST_WR;
                        default: state_d = ST_OP;
                    endcase
                end
            end
            ST_ARG: begin
                // a missing operand byte stretches the instruction
                if (code_valid) begin
                    state_d = (cls_q == CL_RN_DIR) ? ST_WAIT : ST_OP;
                end
            end
            ST_WAIT: state_d = ST_WR;
            ST_WR:   state_d = ST_OP;
            ST_IND:  state_d = ST_OP;
            default: state_d = ST_OP;
        endcase
    end

    // ==========================================================
    // accumulator and carry datapath
    always_comb begin
        acc_d = acc_q;
        cy_d  = cy_q;
        tmp_d = tmp_q;
        if (op_take) begin
            case (cls_now)
                CL_RLC: begin
                    acc_d = {acc_q[6:0], cy_q};
                    cy_d  = acc_q[7];
                end
                CL_RR:  acc_d = {acc_q[0], acc_q[7:1]};
                CL_RRC: begin
                    acc_d = {cy_q, acc_q[7:1]};
                    cy_d  = acc_q[0];
                end
                CL_SWAP: acc_d = {acc_q[3:0], acc_q[7:4]};
                CL_A_RN: acc_d = rn_val;
                default: acc_d = acc_q;
            endcase
        end else if (arg_take) begin
            if (cls_q == CL_A_DIR) acc_d = ram_rdata;
            if (cls_q == CL_A_IMM) acc_d = code_byte;
            if (cls_q == CL_RN_DIR) tmp_d = ram_rdata;
        end else if (ind_read) begin
            acc_d = ram_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_OP;
            cls_q   <= CL_NONE;
            op_q    <= 8'h00;
        end else begin
            state_q <= state_d;
            cls_q   <= cls_d;
            op_q    <= op_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            acc_q <= ACC_RST;
            cy_q  <= CY_RST;
            tmp_q <= 8'h00;
        end else begin
            acc_q <= acc_d;
            cy_q  <= cy_d;
            tmp_q <= tmp_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rf_q <= {NUM_RF{RF_RST}};
        end else if (wr_rf) begin
            rf_q[rn_q] <= wr_val;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_take(logic [7:0] op);
        op_take && code_byte == op;
    endsequence
    sequence s_take_grp(logic [4:0] grp);
        op_take && code_byte[7:3] == grp;
    endsequence

    rlc_exec_a: assert property (
        s_take(OP_RLC) |=> acc_q == {$past(acc_q[6:0]), $past(cy_q)}
            && cy_q == $past(acc_q[7]) && code_ready)
        else $error("rotate left through carry wrong");

    rr_exec_a: assert property (
        s_take(OP_RR) |=> acc_q == {$past(acc_q[0]), $past(acc_q[7:1])}
            && cy_q == $past(cy_q) && code_ready)
        else $error("rotate right wrong");

    rrc_exec_a: assert property (
        s_take(OP_RRC) |=> acc_q == {$past(cy_q), $past(acc_q[7:1])}
            && cy_q == $past(acc_q[0]) && code_ready)
        else $error("rotate right through carry wrong");

    swap_exec_a: assert property (
        s_take(OP_SWAP) |-> done ##1 acc_q == {$past(acc_q[3:0]), $past(acc_q[7:4])})
        else $error("nibble swap wrong");

    mov_a_rn_a: assert property (
        s_take_grp(GRP_A_RN) |-> done ##1 (acc_q == $past(rn_val) && in_op))
        else $error("register to accumulator wrong");

    mov_a_dir_a: assert property (
        s_take(OP_A_DIR) ##1 code_valid |-> ram_req.re && ram_req.addr == code_byte
            && done ##1 (acc_q == $past(ram_rdata) && in_op))
        else $error("direct to accumulator wrong");

    mov_a_ind_a: assert property (
        op_take && code_byte[7:1] == GRP_A_IND |=> ind_read && !code_ready
            && ram_req.re && ram_req.addr == rf_q[{2'b00, $past(code_byte[0])}]
            ##1 (acc_q == $past(ram_rdata) && in_op))
        else $error("indirect to accumulator wrong");

    mov_a_imm_a: assert property (
        s_take(OP_A_IMM) ##1 code_valid |=> acc_q == $past(code_byte) && in_op)
        else $error("immediate to accumulator wrong");

    mov_rn_a_a: assert property (
        s_take_grp(GRP_RN_A) |=> wr_rf && done
            ##1 (rf_q[$past(code_byte[2:0], 2)] == $past(acc_q) && in_op))
        else $error("accumulator to register wrong");

    sequence s_rn_dir_arg;
        s_take_grp(GRP_RN_DIR) ##1 code_valid;
    endsequence
    mov_rn_dir_a: assert property (
        s_rn_dir_arg |=> tmp_q == $past(ram_rdata) && state_q == ST_WAIT
            ##1 wr_rf ##1 (rf_q[rn_q] == $past(tmp_q) && in_op))
        else $error("direct to register wrong");

    ptr_select_a: assert property (
        ind_read |-> ram_req.addr == (op_q[0] ? rf_q[1] : rf_q[0]))
        else $error("pointer register select wrong");

endmodule : armd_core

// ---- core/armd_pkg.sv ----
// armd_pkg: opcodes, decode classes, states and carriers for the
// accumulator rotate and move decoder.
// assumes an 8-bit core with a byte-wide code stream and internal ram.
package armd_pkg;

    // ==========================================================
    // opcodes and opcode groups
    localparam logic [7:0] OP_RLC      = 8'h33;
    localparam logic [7:0] OP_RR       = 8'h03;
    localparam logic [7:0] OP_RRC      = 8'h13;
    localparam logic [7:0] OP_SWAP     = 8'hc4;
    localparam logic [7:0] OP_A_DIR    = 8'he5;
    localparam logic [7:0] OP_A_IMM    = 8'h74;
    localparam logic [4:0] GRP_A_RN    = 5'h1d;  // e8..ef
    localparam logic [4:0] GRP_RN_A    = 5'h1f;  // f8..ff
    localparam logic [4:0] GRP_RN_DIR  = 5'h15;  // a8..af
    localparam logic [6:0] GRP_A_IND   = 7'h73;  // e6..e7

    // ==========================================================
    // reset values
    localparam logic [7:0] ACC_RST     = 8'h00;
    localparam logic       CY_RST      = 1'b0;
    localparam logic [7:0] RF_RST      = 8'h00;
    localparam int         NUM_RF      = 8;

    // ==========================================================
    // types
    typedef enum logic [3:0] {
        CL_NONE, CL_RLC, CL_RR, CL_RRC, CL_SWAP, CL_A_RN,
        CL_A_DIR, CL_A_IND, CL_A_IMM, CL_RN_A, CL_RN_DIR
    } armd_cls_t;

    // gray along op -> arg -> wait -> write
    typedef enum logic [2:0] {
        ST_OP   = 3'b000,
        ST_ARG  = 3'b001,
        ST_WAIT = 3'b011,
        ST_WR   = 3'b010,
        ST_IND  = 3'b110
    } armd_state_t;

    typedef struct packed {
        logic       re;
        logic [7:0] addr;
    } armd_ram_req_t;

    // ==========================================================
    // opcode classification
    function automatic armd_cls_t armd_classify(input logic [7:0] op);
        armd_cls_t c;
        c = CL_NONE;
        if (op == OP_RLC) c = CL_RLC;
        else if (op == OP_RR) c = CL_RR;
        else if (op == OP_RRC) c = CL_RRC;
        else if (op == OP_SWAP) c = CL_SWAP;
        else if (op == OP_A_DIR) c = CL_A_DIR;
        else if (op == OP_A_IMM) c = CL_A_IMM;
        else if (op[7:3] == GRP_A_RN) c = CL_A_RN;
        else if (op[7:3] == GRP_RN_A) c = CL_RN_A;
        else if (op[7:3] == GRP_RN_DIR) c = CL_RN_DIR;
        else if (op[7:1] == GRP_A_IND) c = CL_A_IND;
        return c;
    endfunction : armd_classify

endpackage : armd_pkg

// ---- tb/armd_tb.sv ----
// armd_tb: self-checking bench for the rotate and move decoder.
// assumes armd_pkg and armd_core compiled first; bench plays fetch and ram.
`timescale 1ns/1ns
module tb
    import armd_pkg::*;
();

    logic                clk;
    logic                srst;
    logic                code_valid;
    logic [7:0]          code_byte;
    wire logic           code_ready;
    armd_ram_req_t       ram_req;
    wire logic [7:0]     ram_rdata;
    wire logic [7:0]     acc;
    wire logic           cy;
    wire logic [7:0][7:0] rf;
    wire logic           done;
    wire logic           unhandled;
    int                  bad_count;
    int                  compares;
    int                  re_cnt;
    int                  uh_cnt;
    int                  uh_exp;
    logic [7:0]          last_addr;

    armd_core dut_u (
        .clk        (clk),
        .srst       (srst),
        .code_valid (code_valid),
        .code_byte  (code_byte),
        .code_ready (code_ready),
        .ram_req    (ram_req),
        .ram_rdata  (ram_rdata),
        .acc        (acc),
        .cy         (cy),
        .rf         (rf),
        .done       (done),
        .unhandled  (unhandled)
    );

    // =========================================================
    // ram model: unread cycles show the inverse, not stale data
    assign ram_rdata = ram_req.re ? (ram_req.addr ^ 8'h5a) : ~(ram_req.addr ^ 8'h5a);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [7:0] rv(input logic [3:0] n);
        return {n, ~n};
    endfunction : rv

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // =========================================================
    // one instruction: bytes offered in order, cycles counted to done
    task automatic run(input logic [7:0] op, input int nb, input logic [7:0] opd,
                       input int cyc);
        int n;
        int st;
        bit fin;
        n = 0;
        st = 0;
        fin = 0;
        re_cnt = 0;
        uh_cnt = 0;
        while (!fin && n < 20) begin
            code_valid = (st < nb);
            code_byte = (st == 0) ? op : opd;
            @(negedge clk);
            n++;
            fin = (done === 1'b1);
            if (ram_req.re === 1'b1) begin
                re_cnt++;
                last_addr = ram_req.addr;
            end
            if (unhandled !== 1'b0) uh_cnt++;
            if (code_ready === 1'b1 && st < nb) st++;
            @(posedge clk);
            #1;
        end
        // valid keeps its last-cycle value: the next call or the caller drives it after an edge
        chk("cycles", 8'(cyc), 8'(n));
        chk("bytes", 8'(nb), 8'(st));
        chk("unhandled", 8'(uh_exp), 8'(uh_cnt));
    endtask : run

    task automatic t_reset();
        chk("acc", ACC_RST, acc);
        chk("cy", 8'(CY_RST), 8'(cy));
        for (int i = 0; i < NUM_RF; i++) chk("rf", RF_RST, rf[i]);
    endtask : t_reset

    task automatic t_moves_rn();
        for (int i = 0; i < 8; i++) begin
            run(OP_A_IMM, 2, rv(4'(i)), 2);
            chk("acc", rv(4'(i)), acc);
            run({GRP_RN_A, 3'(i)}, 1, 8'h00, 2);
            chk("rf", rv(4'(i)), rf[i]);
        end
        for (int i = 0; i < 8; i++) begin
            run({GRP_A_RN, 3'(i)}, 1, 8'h00, 1);
            chk("acc", rv(4'(i)), acc);
        end
    endtask : t_moves_rn

    task automatic t_rotates();
        logic [7:0] ops [5] = '{OP_RLC, OP_RR, OP_RRC, OP_RR, OP_SWAP};
        logic [7:0] ea  [5] = '{8'h2c, 8'h16, 8'h8b, 8'hc5, 8'h5c};
        logic       ec  [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        run(OP_A_IMM, 2, 8'h96, 2);
        for (int i = 0; i < 5; i++) begin
            run(ops[i], 1, 8'h00, 1);
            chk("rot acc", ea[i], acc);
            chk("rot cy", 8'(ec[i]), 8'(cy));
        end
    endtask : t_rotates

    task automatic t_direct();
        run(OP_A_DIR, 2, 8'h3c, 2);
        chk("dir addr", 8'h3c, last_addr);
        chk("dir reads", 8'h01, 8'(re_cnt));
        chk("dir acc", 8'h3c ^ 8'h5a, acc);
        for (int i = 0; i < 2; i++) begin
            run({GRP_A_IND, 1'(i)}, 1, 8'h00, 2);
            chk("ind addr", rv(4'(i)), last_addr);
            chk("ind acc", rv(4'(i)) ^ 8'h5a, acc);
        end
        for (int i = 0; i < 8; i++) begin
            run({GRP_RN_DIR, 3'(i)}, 2, 8'h80 + 8'(i), 4);
            chk("rdir addr", 8'h80 + 8'(i), last_addr);
            chk("rdir rf", (8'h80 + 8'(i)) ^ 8'h5a, rf[i]);
        end
    endtask : t_direct

    // =========================================================
    // foreign opcode acts as no-op; a late operand byte stretches the move
    task automatic t_other();
        run(OP_A_IMM, 2, 8'h69, 2);
        uh_exp = 1;
        run(8'h23, 1, 8'h00, 1);
        uh_exp = 0;
        chk("other acc", 8'h69, acc);
        chk("other cy", 8'h00, 8'(cy));
        code_valid = 1'b1;
        code_byte = OP_A_IMM;
        @(posedge clk);
        #1;
        code_valid = 1'b0;
        code_byte = 8'ha5;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("stall done", 8'h00, 8'(done));
        chk("stall acc", 8'h69, acc);
        @(posedge clk);
        #1;
        run(8'ha5, 1, 8'h00, 1);
        chk("late imm", 8'ha5, acc);
    endtask : t_other

    task automatic summarize();
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        bad_count = 0;
        compares = 0;
        uh_exp = 0;
        srst = 1'b1;
        code_valid = 1'b0;
        code_byte = 8'h00;
        repeat (10) @(posedge clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_moves_rn();
        t_rotates();
        t_direct();
        t_other();
        summarize();
    end

    // watchdog: well past the hundred or so cycles the scenarios need
    initial begin
        #20000;
        bad_count++;
        summarize();
    end
endmodule : tb
